// file: gain_ctrl_pkg.sv
// constants, register map and shared decode for the parallel gain control block
// Behaviour
// - mode select low puts gain control into parallel mode
// - mode select floating reads low, so parallel mode is the default
// - shared pins: gain bits 1,0,2,3 in parallel; sdi,sdo,sclk,cs_n in serial
// - parallel gain comes from a 7-bit code, lsb worth 0.25 dB
// - gain spans 6 dB to 26 dB in uniform 0.25 dB steps
// - floating gain pins read high, except bit zero which reads low
// - whole bus floating gives the 6 dB minimum gain
// - parallel pins reach the gain circuit directly, no latch or clock stage, except in shutdown, when a clocked hold register drives it
// - bit weights 0.25, 0.5, 1, 2, 4, 8 dB attenuation for bits zero to five
// - parallel mode gives both channels one gain; serial allows separate gains
// - bit six weighs 16 dB; gain is 26 minus 0.25 times code, above 80 is 6 dB
// - shutdown high turns amplifier off, only in parallel mode
// - shutdown keeps the digital side alive and holds the last active gain
`default_nettype none
package gain_ctrl_pkg;
  localparam int unsigned CODE_W = 7;
  localparam int unsigned QDB_W = 8;
  localparam logic [6:0] CODE_MAX = 7'h50;
  localparam logic [7:0] GAIN_MAX_QDB = 8'h68;
  localparam logic [6:0] PIN_BIAS = 7'h7e;
  localparam logic MODE_BIAS = 1'b0;
  localparam logic MODE_PARALLEL = 1'b0;

  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ATTEN_A = 8'h04;
  localparam logic [7:0] OFS_ATTEN_B = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_PINS = 8'h10;

  localparam int unsigned CTRL_SYNC_BIT = 0;
  localparam int unsigned CTRL_OFF_A_BIT = 1;
  localparam int unsigned CTRL_OFF_B_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [6:0] ATTEN_RESET = 7'h50;

  localparam int unsigned STAT_SERIAL_BIT = 0;
  localparam int unsigned STAT_SHDN_BIT = 1;
  localparam int unsigned STAT_EN_A_BIT = 2;
  localparam int unsigned STAT_EN_B_BIT = 3;
  localparam int unsigned STAT_CODE_A_LSB = 8;
  localparam int unsigned STAT_CODE_B_LSB = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // codes past the top of the range all mean minimum gain
  function automatic logic [6:0] sat_code(input logic [6:0] code);
    sat_code = (code > CODE_MAX) ? CODE_MAX : code;
  endfunction

  // gain in quarter dB: 26 dB is 104 quarters, each code step one quarter
  function automatic logic [7:0] code_to_qdb(input logic [6:0] code);
    code_to_qdb = GAIN_MAX_QDB - {1'b0, sat_code(code)};
  endfunction
endpackage
`default_nettype wire

// file: atten_decode.sv
// combinational attenuation decode: saturated code and gain in quarter dB
`default_nettype none
module atten_decode (
  input wire logic [6:0] code_in,
  output logic [6:0] code_sat,
  output logic [7:0] gain_qdb
);
  // no clock on purpose: gain follows its code in the same instant
  assign code_sat = gain_ctrl_pkg::sat_code(code_in);
  assign gain_qdb = gain_ctrl_pkg::code_to_qdb(code_in);
endmodule
`default_nettype wire

// file: parallel_gain_control.sv
// gain control front end: pin mode mux, parallel decode, axi4-lite registers
`default_nettype none
module parallel_gain_control (
  input wire logic clk_sys,
  input wire logic rst,
  // mode select pin, float flag models an open pin
  input wire logic mode_sel_in,
  input wire logic mode_sel_float,
  // gain pins; bit 0 also carries serial data out
  input wire logic [6:0] gain_bit_in,
  input wire logic [6:0] gain_bit_float,
  output logic gain_bit_0_out,
  output logic gain_bit_0_oe,
  input wire logic amp_shutdown,
  // serial interface side of the shared pins
  output logic ser_sdi,
  output logic ser_sclk,
  output logic ser_cs_n,
  input wire logic ser_sdo,
  // towards the analog gain circuits
  output logic [6:0] chan_a_atten,
  output logic [6:0] chan_b_atten,
  output logic [7:0] chan_a_gain_qdb,
  output logic [7:0] chan_b_gain_qdb,
  output logic chan_a_enable,
  output logic chan_b_enable,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ---------------------------------------------------------------
  // pin resolution and mode
  // ---------------------------------------------------------------
  // an open pin reads its weak bias level
  wire logic mode_pin = mode_sel_float ? gain_ctrl_pkg::MODE_BIAS : mode_sel_in;
  wire logic serial_mode = (mode_pin != gain_ctrl_pkg::MODE_PARALLEL);

  wire logic [6:0] pin_code;
  assign pin_code = (gain_bit_in & ~gain_bit_float)
                  | (gain_ctrl_pkg::PIN_BIAS & gain_bit_float);

  // shared pins: bit1 sdi, bit0 sdo, bit2 sclk, bit3 chip select
  assign ser_sdi = serial_mode & pin_code[1];
  assign ser_sclk = serial_mode & pin_code[2];
  // outside serial mode the serial side sees itself deselected
  assign ser_cs_n = serial_mode ? pin_code[3] : 1'b1;
  // sdo is a current output: on only for a high bit while selected
  assign gain_bit_0_oe = serial_mode & ~pin_code[3] & ser_sdo;
  assign gain_bit_0_out = ser_sdo;

  // ---------------------------------------------------------------
  // parallel path
  // ---------------------------------------------------------------
  wire logic par_shdn = ~serial_mode & amp_shutdown;

  // hold register tracks the live code one clock late outside shutdown and freezes during it
  logic [6:0] held_code_reg;
  logic [6:0] held_code_next;
  assign held_code_next = par_shdn ? held_code_reg : pin_code;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      held_code_reg <= gain_ctrl_pkg::CODE_MAX;
    end else begin
      held_code_reg <= held_code_next;
    end
  end

  // while shut down the last active setting stays applied
  wire logic [6:0] par_code = par_shdn ? held_code_reg : pin_code;

  // ---------------------------------------------------------------
  // software registers (serial-mode gain and power)
  // ---------------------------------------------------------------
  logic [2:0] ctrl_reg;
  logic [6:0] atten_a_reg;
  logic [6:0] atten_b_reg;

  wire logic sync_mode = ctrl_reg[gain_ctrl_pkg::CTRL_SYNC_BIT];
  wire logic [6:0] ser_code_a = atten_a_reg;
  wire logic [6:0] ser_code_b = sync_mode ? atten_a_reg : atten_b_reg;

  // parallel mode drives one common code into both channels
  wire logic [6:0] code_a_raw = serial_mode ? ser_code_a : par_code;
  wire logic [6:0] code_b_raw = serial_mode ? ser_code_b : par_code;

  atten_decode dec_a (
    .code_in(code_a_raw),
    .code_sat(chan_a_atten),
    .gain_qdb(chan_a_gain_qdb)
  );

  atten_decode dec_b (
    .code_in(code_b_raw),
    .code_sat(chan_b_atten),
    .gain_qdb(chan_b_gain_qdb)
  );

  // shutdown pin only counts in parallel mode; serial uses its own bits
  wire logic off_a = serial_mode ? ctrl_reg[gain_ctrl_pkg::CTRL_OFF_A_BIT] : amp_shutdown;
  wire logic off_b = serial_mode ? ctrl_reg[gain_ctrl_pkg::CTRL_OFF_B_BIT] : amp_shutdown;
  assign chan_a_enable = ~off_a;
  assign chan_b_enable = ~off_b;

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  logic aw_got_reg;
  logic aw_got_next;
  logic w_got_reg;
  logic w_got_next;
  logic [7:0] waddr_reg;
  logic [7:0] waddr_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic [3:0] wstrb_reg;
  logic [3:0] wstrb_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;

  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic b_done = bvalid_reg & s_axi_bready;
  // the write lands one cycle after both halves are held
  wire logic do_write = aw_got_reg & w_got_reg & ~bvalid_reg;

  // one register per aligned word, so only bits 7:2 pick it
  function automatic logic word_is(input logic [7:0] addr, input logic [7:0] ofs);
    word_is = (addr[7:2] == ofs[7:2]);
  endfunction

  wire logic wr_ctrl = do_write & word_is(waddr_reg, gain_ctrl_pkg::OFS_CTRL);
  wire logic wr_atten_a = do_write & word_is(waddr_reg, gain_ctrl_pkg::OFS_ATTEN_A);
  wire logic wr_atten_b = do_write & word_is(waddr_reg, gain_ctrl_pkg::OFS_ATTEN_B);
  wire logic wr_hit = wr_ctrl | wr_atten_a | wr_atten_b;
  // status words are read only, so writes to them report an error too
  wire logic wr_lane0 = wstrb_reg[0];

  assign aw_got_next = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_got_reg);
  assign w_got_next = w_take ? 1'b1 : (do_write ? 1'b0 : w_got_reg);
  assign waddr_next = aw_take ? s_axi_awaddr : waddr_reg;
  assign wdata_next = w_take ? s_axi_wdata : wdata_reg;
  assign wstrb_next = w_take ? s_axi_wstrb : wstrb_reg;
  assign bvalid_next = do_write ? 1'b1 : (b_done ? 1'b0 : bvalid_reg);
  assign bresp_next = do_write
                    ? (wr_hit ? gain_ctrl_pkg::RESP_OKAY : gain_ctrl_pkg::RESP_SLVERR)
                    : bresp_reg;

  // next register values; only byte lane 0 carries fields
  logic [2:0] ctrl_next;
  logic [6:0] atten_a_next;
  logic [6:0] atten_b_next;
  assign ctrl_next = (wr_ctrl & wr_lane0) ? wdata_reg[2:0] : ctrl_reg;
  assign atten_a_next = (wr_atten_a & wr_lane0) ? wdata_reg[6:0] : atten_a_reg;
  assign atten_b_next = (wr_atten_b & wr_lane0) ? wdata_reg[6:0] : atten_b_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= gain_ctrl_pkg::RESP_OKAY;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= gain_ctrl_pkg::CTRL_RESET;
      atten_a_reg <= gain_ctrl_pkg::ATTEN_RESET;
      atten_b_reg <= gain_ctrl_pkg::ATTEN_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      atten_a_reg <= atten_a_next;
      atten_b_reg <= atten_b_next;
    end
  end

  // ready is registered; low while a half is held or a response waits
  logic awready_reg;
  logic wready_reg;
  wire logic awready_next = ~aw_got_next & ~bvalid_next & ~do_write;
  wire logic wready_next = ~w_got_next & ~bvalid_next & ~do_write;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  logic arready_reg;
  logic arready_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  wire logic ar_take = s_axi_arvalid & arready_reg;
  wire logic r_done = rvalid_reg & s_axi_rready;

  // field positions are the named ones, so the map cannot drift from them
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[gain_ctrl_pkg::STAT_SERIAL_BIT] = serial_mode;
    status_word[gain_ctrl_pkg::STAT_SHDN_BIT] = par_shdn;
    status_word[gain_ctrl_pkg::STAT_EN_A_BIT] = chan_a_enable;
    status_word[gain_ctrl_pkg::STAT_EN_B_BIT] = chan_b_enable;
    status_word[gain_ctrl_pkg::STAT_CODE_A_LSB +: 7] = chan_a_atten;
    status_word[gain_ctrl_pkg::STAT_CODE_B_LSB +: 7] = chan_b_atten;
  end

  wire logic rd_ctrl = word_is(s_axi_araddr, gain_ctrl_pkg::OFS_CTRL);
  wire logic rd_atten_a = word_is(s_axi_araddr, gain_ctrl_pkg::OFS_ATTEN_A);
  wire logic rd_atten_b = word_is(s_axi_araddr, gain_ctrl_pkg::OFS_ATTEN_B);
  wire logic rd_status = word_is(s_axi_araddr, gain_ctrl_pkg::OFS_STATUS);
  wire logic rd_pins = word_is(s_axi_araddr, gain_ctrl_pkg::OFS_PINS);
  wire logic rd_hit = rd_ctrl | rd_atten_a | rd_atten_b | rd_status | rd_pins;

  wire logic [31:0] rd_word;
  assign rd_word = rd_ctrl ? {29'h0000_0000, ctrl_reg}
                 : rd_atten_a ? {25'h000_0000, atten_a_reg}
                 : rd_atten_b ? {25'h000_0000, atten_b_reg}
                 : rd_status ? status_word
                 : rd_pins ? {25'h000_0000, pin_code}
                 : 32'h0000_0000;

  assign rvalid_next = ar_take ? 1'b1 : (r_done ? 1'b0 : rvalid_reg);
  assign rdata_next = ar_take ? rd_word : rdata_reg;
  assign rresp_next = ar_take
                    ? (rd_hit ? gain_ctrl_pkg::RESP_OKAY : gain_ctrl_pkg::RESP_SLVERR)
                    : rresp_reg;
  // one read at a time: ready drops from the take until the data is gone
  assign arready_next = ~rvalid_next;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= gain_ctrl_pkg::RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule
`default_nettype wire

// file: parallel_gain_control_properties.sv
// concurrent checks on the parallel gain control pins and gain outputs
`default_nettype none
module parallel_gain_control_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mode_sel_in,
  input wire logic mode_sel_float,
  input wire logic [6:0] gain_bit_in,
  input wire logic [6:0] gain_bit_float,
  input wire logic gain_bit_0_out,
  input wire logic gain_bit_0_oe,
  input wire logic amp_shutdown,
  input wire logic ser_sdi,
  input wire logic ser_sclk,
  input wire logic ser_cs_n,
  input wire logic ser_sdo,
  input wire logic [6:0] chan_a_atten,
  input wire logic [6:0] chan_b_atten,
  input wire logic [7:0] chan_a_gain_qdb,
  input wire logic [7:0] chan_b_gain_qdb,
  input wire logic chan_a_enable,
  input wire logic chan_b_enable
);
  logic serial;
  logic [6:0] pins;
  logic [6:0] want;
  // open pins take their bias, not whatever the line shows
  assign serial = mode_sel_float ? 1'b0 : mode_sel_in;
  assign pins = (gain_bit_in & ~gain_bit_float) | (7'h7e & gain_bit_float);
  assign want = (pins > 7'h50) ? 7'h50 : pins;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_pin_decode: assert property (!serial && !amp_shutdown |-> chan_a_atten == want)
    else $error("parallel code not applied");
  a_gain_qdb: assert property (chan_a_gain_qdb == 8'h68 - {1'b0, chan_a_atten} && chan_b_gain_qdb == 8'h68 - {1'b0, chan_b_atten})
    else $error("gain does not match code");
  a_one_gain: assert property (!serial |-> chan_b_atten == chan_a_atten && chan_b_enable == chan_a_enable)
    else $error("channels differ in parallel mode");
  a_shut_power: assert property (!serial |-> chan_a_enable == !amp_shutdown)
    else $error("enable does not follow shutdown");
  a_shut_hold: assert property (!serial && amp_shutdown && $past(amp_shutdown) && !$past(serial) && !$past(rst) |-> $stable(chan_a_atten))
    else $error("code moved during shutdown");
  a_float_min: assert property (!serial && !amp_shutdown && gain_bit_float == 7'h7f |-> chan_a_atten == 7'h50 && chan_a_gain_qdb == 8'h18)
    else $error("open bus not at minimum gain");
  a_mode_float: assert property (mode_sel_float |-> ser_cs_n && !gain_bit_0_oe)
    else $error("open mode pin not parallel");
  a_pin_share: assert property (serial |-> ser_sdi == pins[1] && ser_sclk == pins[2] && ser_cs_n == pins[3])
    else $error("serial pin mapping wrong");
  a_sdo_drive: assert property (gain_bit_0_oe == (serial && !pins[3] && ser_sdo) && (!gain_bit_0_oe || gain_bit_0_out == ser_sdo))
    else $error("data out drive wrong");
endmodule
bind parallel_gain_control parallel_gain_control_checker i_chk (.clk_sys, .rst, .mode_sel_in,
  .mode_sel_float, .gain_bit_in, .gain_bit_float, .gain_bit_0_out, .gain_bit_0_oe, .amp_shutdown,
  .ser_sdi, .ser_sclk, .ser_cs_n, .ser_sdo, .chan_a_atten, .chan_b_atten, .chan_a_gain_qdb,
  .chan_b_gain_qdb, .chan_a_enable, .chan_b_enable);
`default_nettype wire

// file: pin_strap_model.sv
// far-side controller model driving the gain pins and sharing pin 14
`default_nettype none
module pin_strap_model (
  input wire logic clk_sys,
  input wire logic [6:0] code,
  input wire logic [6:0] float_mask,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  output logic [6:0] pin_level
);
  logic [6:0] last_reg = 7'h00;
  logic [6:0] driven;
  // open pins 6:1 wander every cycle, so only the bias may decide them
  assign driven = (code & ~float_mask) | (~last_reg & float_mask);
  // a released data-out line sits at its pull-down level, not the last value
  assign pin_level = {driven[6:1], sdo_oe ? sdo_out : (driven[0] & ~float_mask[0])};
  always_ff @(posedge clk_sys) begin
    last_reg <= pin_level;
  end
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench: pin scenarios and register accesses
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic mode_sel_in = 1'b0, mode_sel_float = 1'b0, amp_shutdown = 1'b0, ser_sdo = 1'b0;
  logic [6:0] pin_code = 7'h00, pin_float = 7'h00, gain_bit_in, chan_a_atten, chan_b_atten;
  logic gain_bit_0_out, gain_bit_0_oe, ser_sdi, ser_sclk, ser_cs_n, chan_a_enable, chan_b_enable;
  logic [7:0] chan_a_gain_qdb, chan_b_gain_qdb, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0;
  int checks = 0;
  logic [6:0] codes [12] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h50,
    7'h51, 7'h5a, 7'h7f};
  pin_strap_model i_pins (.clk_sys(clk_sys), .code(pin_code), .float_mask(pin_float),
    .sdo_out(gain_bit_0_out), .sdo_oe(gain_bit_0_oe), .pin_level(gain_bit_in));
  parallel_gain_control i_dut (.clk_sys, .rst, .mode_sel_in, .mode_sel_float, .gain_bit_in,
    .gain_bit_float(pin_float), .gain_bit_0_out, .gain_bit_0_oe, .amp_shutdown, .ser_sdi,
    .ser_sclk, .ser_cs_n, .ser_sdo, .chan_a_atten, .chan_b_atten, .chan_a_gain_qdb,
    .chan_b_gain_qdb, .chan_a_enable, .chan_b_enable, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_up(input int n);
    if (n >= 50) begin
      num_errors++;
      $display("ERROR %0t bus answer never came", $time);
      complete_run();
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    give_up(n);
    chk(s_axi_bresp, er);
  endtask
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    give_up(n);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  // checks land 1 ns after the edge, before any later edge could latch the pins
  task automatic set_pins(input logic [6:0] c, input logic [6:0] f, input logic sd);
    @(posedge clk_sys);
    pin_code <= c;
    pin_float <= f;
    amp_shutdown <= sd;
    #1;
  endtask
  task automatic par_chk(input logic [6:0] ea, input logic en);
    chk(chan_a_atten, ea);
    chk(chan_b_atten, ea);
    chk(chan_a_gain_qdb, 8'h68 - ea);
    chk(chan_b_gain_qdb, 8'h68 - ea);
    chk({chan_a_enable, chan_b_enable}, {en, en});
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (codes[i]) begin
      set_pins(codes[i], 7'h00, 1'b0);
      par_chk((codes[i] > 7'h50) ? 7'h50 : codes[i], 1'b1);
    end
    set_pins(7'h00, 7'h7f, 1'b0);
    par_chk(7'h50, 1'b1);
    set_pins(7'h01, 7'h01, 1'b0);
    par_chk(7'h00, 1'b1);
    set_pins(7'h00, 7'h02, 1'b0);
    par_chk(7'h02, 1'b1);
    set_pins(7'h08, 7'h00, 1'b0);
    set_pins(7'h08, 7'h00, 1'b1);
    par_chk(7'h08, 1'b0);
    set_pins(7'h10, 7'h00, 1'b1);
    par_chk(7'h08, 1'b0);
    set_pins(7'h10, 7'h00, 1'b0);
    par_chk(7'h10, 1'b1);
    @(posedge clk_sys);
    mode_sel_in <= 1'b1;
    mode_sel_float <= 1'b1;
    set_pins(7'h20, 7'h00, 1'b0);
    par_chk(7'h20, 1'b1);
    @(posedge clk_sys);
    mode_sel_float <= 1'b0;
    ser_sdo <= 1'b1;
    set_pins(7'h02, 7'h00, 1'b1);
    chk({ser_sdi, ser_sclk, ser_cs_n, gain_bit_0_oe, gain_bit_0_out}, 5'b10011);
    chk({chan_a_enable, chan_b_enable}, 2'b11);
    set_pins(7'h0c, 7'h00, 1'b1);
    chk({ser_sdi, ser_sclk, ser_cs_n, gain_bit_0_oe, gain_bit_0_out}, 5'b01101);
    axi_read(gain_ctrl_pkg::OFS_PINS, 32'h0c, gain_ctrl_pkg::RESP_OKAY);
    axi_read(gain_ctrl_pkg::OFS_ATTEN_A, 32'h50, gain_ctrl_pkg::RESP_OKAY);
    axi_write(gain_ctrl_pkg::OFS_ATTEN_A, 32'h14, gain_ctrl_pkg::RESP_OKAY);
    axi_write(gain_ctrl_pkg::OFS_ATTEN_B, 32'h7f, gain_ctrl_pkg::RESP_OKAY);
    #1;
    chk({chan_a_atten, chan_b_atten}, {7'h14, 7'h50});
    axi_read(gain_ctrl_pkg::OFS_ATTEN_A, 32'h14, gain_ctrl_pkg::RESP_OKAY);
    // lane 0 off: answered, but the register must keep its value
    s_axi_wstrb <= 4'h0;
    axi_write(gain_ctrl_pkg::OFS_ATTEN_A, 32'h33, gain_ctrl_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    axi_read(gain_ctrl_pkg::OFS_ATTEN_A, 32'h14, gain_ctrl_pkg::RESP_OKAY);
    axi_write(gain_ctrl_pkg::OFS_CTRL, 32'h1, gain_ctrl_pkg::RESP_OKAY);
    #1;
    chk(chan_b_atten, 7'h14);
    axi_write(gain_ctrl_pkg::OFS_CTRL, 32'h6, gain_ctrl_pkg::RESP_OKAY);
    #1;
    chk({chan_a_enable, chan_b_enable}, 2'b00);
    axi_read(gain_ctrl_pkg::OFS_CTRL, 32'h6, gain_ctrl_pkg::RESP_OKAY);
    axi_write(gain_ctrl_pkg::OFS_STATUS, 32'h0, gain_ctrl_pkg::RESP_SLVERR);
    axi_write(8'h20, 32'h0, gain_ctrl_pkg::RESP_SLVERR);
    axi_read(8'h20, 32'h0, gain_ctrl_pkg::RESP_SLVERR);
    axi_read(gain_ctrl_pkg::OFS_STATUS, 32'h00501401, gain_ctrl_pkg::RESP_OKAY);
    @(posedge clk_sys);
    mode_sel_in <= 1'b0;
    set_pins(7'h28, 7'h00, 1'b0);
    par_chk(7'h28, 1'b1);
    set_pins(7'h28, 7'h00, 1'b1);
    par_chk(7'h28, 1'b0);
    axi_read(gain_ctrl_pkg::OFS_STATUS, 32'h00282802, gain_ctrl_pkg::RESP_OKAY);
    complete_run();
  end
endmodule
`default_nettype wire
